// >>> inc/osp_pkg.sv
// Constants shared by the octal switch parallel control block
package osp_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_FREQ_HZ = 200000000;
    localparam int REFRESH_FREQ_HZ = 15000;
    // Period rounded down so the refresh is never slower than specified
    localparam int REFRESH_CYCLES = CLK_FREQ_HZ / REFRESH_FREQ_HZ;
    localparam int UPDATE_TIMEOUT_US = 320;
    localparam int WD_CYCLES = UPDATE_TIMEOUT_US * (CLK_FREQ_HZ / 1000000);
    localparam int XFER_PULSE_MIN_US = 20;
    localparam int XFER_PULSE_MAX_US = 195;
    localparam int XFER_PULSE_MIN_CYCLES = XFER_PULSE_MIN_US * (CLK_FREQ_HZ / 1000000);
    localparam int XFER_PULSE_MAX_CYCLES = XFER_PULSE_MAX_US * (CLK_FREQ_HZ / 1000000);
    // Length of one frame across the isolation barrier
    localparam int FRAME_CYCLES = 16;
    localparam int NUM_CH = 8;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    localparam int CTRL_REFRESH_EN_BIT = 0;
    localparam int CTRL_CORRUPT_BIT = 1;
    localparam logic CTRL_REFRESH_EN_RST = 1'b1;
    localparam int STAT_OUT_LSB = 0;
    localparam int STAT_INBUF_LSB = 8;
    localparam int STAT_TXBUF_LSB = 16;
    localparam int STAT_WD_BIT = 24;
    localparam int STAT_ERR_BIT = 25;
    localparam int STAT_GATE_BIT = 26;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// >>> design/osp_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module osp_sync3
    import osp_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } osp_sync_s;

    osp_sync_s r_reg;
    osp_sync_s r_next;

    // ==========================================================
    // Stages
    // ==========================================================
    // First stage feeds only the second; a change counts when 2 and 3 agree
    always_comb
    begin
        r_next = r_reg;
        r_next.s1 = pin;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (r_reg.s2[i] == r_reg.s3[i])
            begin
                r_next.q[i] = r_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.q;
endmodule

// >>> design/osp_out_stage.sv
// Isolated output stage: frame receiver, watchdog and output gating
`timescale 1ns/1ps
module osp_out_stage
    import osp_pkg::*;
#(
    parameter int WD_LEN = WD_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic upd_valid,
    input wire logic [NUM_CH-1:0] upd_data,
    input wire logic upd_refresh,
    input wire logic upd_corrupt,
    input wire logic gate,
    output logic [NUM_CH-1:0] channel_out,
    output logic wd_expired,
    output logic comm_error
);
    localparam int CW = $clog2(WD_LEN + 1);
    localparam logic [CW-1:0] WD_LAST = CW'(WD_LEN - 1);

    typedef struct packed {
        logic [NUM_CH-1:0] cfg;
        logic [CW-1:0] cnt;
        logic expired;
        logic err;
    } osp_out_s;

    osp_out_s r_reg;
    osp_out_s r_next;

    always_comb
    begin
        r_next = r_reg;
        // RULE_07 timeout count
        if (r_reg.cnt == WD_LAST)
        begin
            r_next.expired = 1'b1;
        end
        else
        begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end
        if (upd_valid)
        begin
            if (!upd_corrupt)
            begin
                // RULE_08 refresh restarts watchdog
                r_next.cfg = upd_data;
                r_next.cnt = '0;
                r_next.expired = 1'b0;
                r_next.err = 1'b0;
            end
            else if (upd_refresh)
            begin
                // RULE_19 corrupt refresh: off
                r_next.cfg = '0;
                r_next.err = 1'b1;
            end
            else
            begin
                // RULE_19 corrupt apply: hold
                r_next.err = 1'b1;
            end
        end
        // RULE_07 expired forces off
        if (r_next.expired)
        begin
            r_next.cfg = '0;
        end
        // RULE_01 gate low forces off
        if (!gate)
        begin
            r_next.cfg = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // RULE_21 outputs off, counter restarted
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign channel_out = r_reg.cfg;
    assign wd_expired = r_reg.expired;
    assign comm_error = r_reg.err;
endmodule

// >>> design/osp_top.sv
// Host-side parallel control logic with AHB-Lite status and control
// Function
// RULE_01 - Output gate low turns all eight outputs off and keeps them off.
// RULE_02 - Capture strobe low alone loads channel inputs into input buffer.
// RULE_03 - Both strobes high: outputs hold, channel inputs ignored.
// RULE_04 - Transfer strobe low alone: refresh suspended, input buffer copied to transmit buffer.
// RULE_05 - Both strobes low: direct mode, each input drives its output.
// RULE_06 - A periodic refresh resends the configuration to the output side.
// RULE_07 - No update within timeout turns outputs off until next update.
// RULE_08 - Each refresh counts as an update and restarts the timeout; here a corrupt refresh leaves the timeout running.
// RULE_09 - Host holds output gate low at least its minimum pulse width.
// RULE_10 - Tied strobes high keep the present output configuration.
// RULE_11 - Strobes tied low: outputs follow inputs except while gate low.
// RULE_12 - Host captures first, then holds transfer strobe low long enough.
// RULE_13 - Transfer strobe low suspends refresh, running frame completes.
// RULE_14 - Transfer strobe rising edge applies the stored configuration.
// RULE_15 - Respected transfer pulse keeps output jitter within the latched limit.
// RULE_16 - Devices sharing transfer strobe switch together within delay bounds.
// RULE_17 - Host avoids both strobes low in latched mode.
// RULE_18 - Host keeps transfer strobe low between 20 and 195 microseconds.
// RULE_19 - Corrupt frame holds outputs; corrupt refresh turns them off.
// RULE_20 - Pins are synchronised before their levels or edges are used.
// RULE_21 - Reset clears buffers, outputs off, watchdog restarted.
`timescale 1ns/1ps
module osp_top
    import osp_pkg::*;
#(
    parameter int REFRESH_LEN = REFRESH_CYCLES,
    parameter int WD_LEN = WD_CYCLES,
    parameter int FRAME_LEN = FRAME_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_CH-1:0] channel_in,
    input wire logic capture_strobe_n,
    input wire logic transfer_strobe_n,
    input wire logic output_gate,
    output logic [NUM_CH-1:0] channel_out
);
    localparam int RW = $clog2(REFRESH_LEN + 1);
    localparam int FW = $clog2(FRAME_LEN + 1);
    localparam logic [RW-1:0] REF_LAST = RW'(REFRESH_LEN - 1);
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_LEN - 1);

    typedef struct packed {
        // Host-side buffers and pin history
        logic [NUM_CH-1:0] in_buf;
        logic [NUM_CH-1:0] tx_buf;
        logic xfer_prev;
        logic gate_prev;
        logic apply_pend;
        logic refresh_pend;
        // Frame engine towards the isolated side
        logic busy;
        logic [FW-1:0] frame_cnt;
        logic [NUM_CH-1:0] frame_data;
        logic frame_refresh;
        logic frame_corrupt;
        // Refresh timer and control register
        logic [RW-1:0] ref_cnt;
        logic refresh_en;
        logic corrupt_req;
        logic dp_act;
        logic dp_wr;
        logic [ADDR_W-1:0] dp_addr;
        logic [31:0] rdata;
    } osp_top_s;

    osp_top_s r_reg;
    osp_top_s r_next;

    logic [NUM_CH-1:0] ch_q;
    logic cap_q;
    logic xfer_q;
    logic gate_q;
    logic upd_valid;
    logic wd_expired;
    logic comm_error;
    logic direct;
    logic suspend;
    logic apply_edge;
    logic launch_apply;
    logic launch_refresh;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic frame_done;
    logic launch;
    logic gate_rise;
    logic capture_en;
    logic copy_en;
    logic direct_upd;
    logic ref_wrap;
    logic addr_take;
    logic ctrl_wr;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // RULE_20 channel inputs
    osp_sync3 #(
        .WIDTH(NUM_CH),
        .RST_VAL('0)
    ) u_sync_ch (
        .clk(hclk),
        .rst_n(hresetn),
        .pin(channel_in),
        .q(ch_q)
    );

    // RULE_20 strobes and gate; strobes idle high, gate idle low
    osp_sync3 #(
        .WIDTH(3),
        .RST_VAL(3'h6)
    ) u_sync_ctl (
        .clk(hclk),
        .rst_n(hresetn),
        .pin({capture_strobe_n, transfer_strobe_n, output_gate}),
        .q({cap_q, xfer_q, gate_q})
    );

    // ==========================================================
    // Mode decode
    // ==========================================================
    // RULE_05 both strobes low
    assign direct = !cap_q && !xfer_q;
    // RULE_13 suspend refresh while transfer strobe low alone
    assign suspend = cap_q && !xfer_q;
    // RULE_14 rising transfer strobe in latched mode
    assign apply_edge = xfer_q && !r_reg.xfer_prev && cap_q;
    // Applies win over refresh so a transfer strobe edge is never delayed
    assign launch_apply = !r_reg.busy && r_reg.apply_pend;
    assign launch_refresh = !r_reg.busy && !r_reg.apply_pend && r_reg.refresh_pend && !suspend;
    // RULE_13 last cycle of a running frame
    assign frame_done = r_reg.busy && (r_reg.frame_cnt == FRAME_LAST);
    assign upd_valid = frame_done;
    // Apply and refresh share one engine, so frames never overlap
    assign launch = launch_apply || launch_refresh;
    // RULE_02 capture window
    assign capture_en = !cap_q && xfer_q && gate_q;
    // RULE_04 copy window
    assign copy_en = suspend && gate_q;
    // Gate low wiped the outputs, so a gate rise in direct mode resends
    assign gate_rise = gate_q && !r_reg.gate_prev;
    // RULE_11 new input word, or outputs to restore after the gate
    assign direct_upd = direct && gate_q && ((ch_q != r_reg.tx_buf) || gate_rise);
    // RULE_06 end of refresh period
    assign ref_wrap = (r_reg.ref_cnt == REF_LAST);

    // ==========================================================
    // Bus decode
    // ==========================================================
    // SEQ is taken like NONSEQ; bursts are not expected but stay harmless
    assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign ctrl_wr = r_reg.dp_act && r_reg.dp_wr && (r_reg.dp_addr == CTRL_ADDR);

    always_comb
    begin
        status_word = '0;
        status_word[STAT_OUT_LSB +: NUM_CH] = channel_out;
        status_word[STAT_INBUF_LSB +: NUM_CH] = r_reg.in_buf;
        status_word[STAT_TXBUF_LSB +: NUM_CH] = r_reg.tx_buf;
        status_word[STAT_WD_BIT] = wd_expired;
        status_word[STAT_ERR_BIT] = comm_error;
        status_word[STAT_GATE_BIT] = gate_q;
    end

    // ==========================================================
    // Read mux
    // ==========================================================
    // Unmapped offsets read zero; the word is latched at the address phase
    always_comb
    begin
        rd_word = '0;
        unique case (haddr[ADDR_W-1:0])
            CTRL_ADDR:
            begin
                rd_word[CTRL_REFRESH_EN_BIT] = r_reg.refresh_en;
                rd_word[CTRL_CORRUPT_BIT] = r_reg.corrupt_req;
            end
            STAT_ADDR:
            begin
                rd_word = status_word;
            end
            default:
            begin
                rd_word = '0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        r_next = r_reg;
        r_next.xfer_prev = xfer_q;
        r_next.gate_prev = gate_q;

        // RULE_02 capture into input buffer
        if (capture_en)
        begin
            r_next.in_buf = ch_q;
        end

        // RULE_04 copy to transmit buffer
        if (copy_en)
        begin
            r_next.tx_buf = r_reg.in_buf;
        end

        // RULE_05 direct drive; RULE_11 tied low follows inputs
        if (direct_upd)
        begin
            r_next.in_buf = ch_q;
            r_next.tx_buf = ch_q;
            r_next.apply_pend = 1'b1;
        end

        // RULE_03 both high: nothing above fires; RULE_10 likewise
        // RULE_14 schedule apply on rising edge
        if (apply_edge)
        begin
            r_next.apply_pend = 1'b1;
        end

        // RULE_06 refresh timer
        if (ref_wrap)
        begin
            r_next.ref_cnt = '0;
            if (r_reg.refresh_en)
            begin
                r_next.refresh_pend = 1'b1;
            end
        end
        else
        begin
            r_next.ref_cnt = r_reg.ref_cnt + 1'b1;
        end

        // RULE_13 running frame always completes
        if (r_reg.busy)
        begin
            if (r_reg.frame_cnt == FRAME_LAST)
            begin
                r_next.busy = 1'b0;
            end
            else
            begin
                r_next.frame_cnt = r_reg.frame_cnt + 1'b1;
            end
        end
        else if (launch)
        begin
            // RULE_15 idle engine at the edge gives fixed latency
            // RULE_16 same latency on every device sharing the strobe
            r_next.busy = 1'b1;
            r_next.frame_cnt = '0;
            r_next.frame_data = r_reg.tx_buf;
            r_next.frame_refresh = launch_refresh;
            r_next.frame_corrupt = r_reg.corrupt_req;
            r_next.corrupt_req = 1'b0;
            if (launch_apply)
            begin
                r_next.apply_pend = 1'b0;
            end
            else
            begin
                r_next.refresh_pend = 1'b0;
            end
        end

        // Bus data phase: write after the launch so a new request is kept
        if (ctrl_wr)
        begin
            r_next.refresh_en = hwdata[CTRL_REFRESH_EN_BIT];
            if (hwdata[CTRL_CORRUPT_BIT])
            begin
                r_next.corrupt_req = 1'b1;
            end
        end

        // Bus address phase; read data captured here, shown next cycle
        r_next.dp_act = 1'b0;
        if (addr_take)
        begin
            r_next.dp_act = 1'b1;
            r_next.dp_wr = hwrite;
            r_next.dp_addr = haddr[ADDR_W-1:0];
            r_next.rdata = hwrite ? 32'h0 : rd_word;
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // RULE_21 buffers cleared
            r_reg <= '0;
            r_reg.xfer_prev <= 1'b1;
            r_reg.refresh_en <= CTRL_REFRESH_EN_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Isolated side
    // ==========================================================
    osp_out_stage #(
        .WD_LEN(WD_LEN)
    ) u_out (
        .clk(hclk),
        .rst_n(hresetn),
        .upd_valid(upd_valid),
        .upd_data(r_reg.frame_data),
        .upd_refresh(r_reg.frame_refresh),
        .upd_corrupt(r_reg.frame_corrupt),
        .gate(gate_q),
        .channel_out(channel_out),
        .wd_expired(wd_expired),
        .comm_error(comm_error)
    );

    // Zero wait states; hsize is not checked, only word access is defined
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r_reg.rdata;
endmodule

// >>> verif/osp_monitor.sv
// Port checker for the octal switch parallel control block
`timescale 1ns/1ps
module osp_monitor
    import osp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [NUM_CH-1:0] channel_in,
    input wire logic capture_strobe_n,
    input wire logic transfer_strobe_n,
    input wire logic output_gate,
    input wire logic [NUM_CH-1:0] channel_out
);
    // ==========================================================
    // Helper state
    // ==========================================================
    logic [9:0] susp_cnt_reg;
    logic [9:0] dir_cnt_reg;
    logic [7:0] inbuf_reg;
    logic [7:0] prev_in_reg;
    wire susp = capture_strobe_n && !transfer_strobe_n && output_gate;
    wire dir = !capture_strobe_n && !transfer_strobe_n && output_gate;
    wire rd_go = hsel && hready && htrans[1] && !hwrite;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            susp_cnt_reg <= '0;
            dir_cnt_reg <= '0;
            inbuf_reg <= '0;
            prev_in_reg <= '0;
        end
        else
        begin
            // Counters saturate so long pulses never wrap back to zero
            susp_cnt_reg <= susp ? susp_cnt_reg + {9'h0, ~&susp_cnt_reg} : '0;
            dir_cnt_reg <= (dir && channel_in == prev_in_reg) ?
                dir_cnt_reg + {9'h0, ~&dir_cnt_reg} : '0;
            prev_in_reg <= channel_in;
            if (!capture_strobe_n && transfer_strobe_n && output_gate)
                inbuf_reg <= channel_in;
        end
    end
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence gate_held_s;
        (!output_gate) [*8];
    endsequence
    sequence apply_s;
        (susp_cnt_reg >= 10'd40) ##0 (capture_strobe_n && transfer_strobe_n && output_gate);
    endsequence
    a_gate_off: assert property (gate_held_s |-> channel_out == 8'h00)
        else $error("output on while gate low");
    a_gate_rise_hold: assert property (gate_held_s ##1 output_gate |->
        channel_out == 8'h00 [*5]) else $error("output back too early after gate");
    a_reset_clear: assert property ($rose(hresetn) |->
        channel_out == 8'h00 && hrdata == 32'h0) else $error("state not cleared");
    a_suspend_hold: assert property (susp && susp_cnt_reg >= 10'd40 &&
        susp_cnt_reg < 10'd600 |-> $stable(channel_out)) else $error("output moved");
    a_apply_value: assert property (apply_s |-> ##[18:40] channel_out == inbuf_reg)
        else $error("stored value not applied");
    a_direct_follow: assert property (dir_cnt_reg >= 10'd40 |->
        channel_out == channel_in) else $error("direct output mismatch");
    a_stat_read: assert property (rd_go && haddr[7:0] == STAT_ADDR |=>
        hrdata[7:0] == $past(channel_out)) else $error("status read mismatch");
    a_unmapped_zero: assert property (rd_go && haddr[7:0] == 8'h08 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
endmodule

bind osp_top osp_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .channel_in, .capture_strobe_n, .transfer_strobe_n,
    .output_gate, .channel_out);

// >>> verif/osp_host.sv
// Host controller model driving the strobe, gate and channel pins
`timescale 1ns/1ps
module osp_host
    import osp_pkg::*;
#(
    parameter int GATE_MIN_CYCLES = 30
)
(
    input wire logic clk,
    output logic [NUM_CH-1:0] channel_in,
    output logic capture_strobe_n,
    output logic transfer_strobe_n,
    output logic output_gate
);
    initial
    begin
        channel_in = 8'h00;
        capture_strobe_n = 1'b1;
        transfer_strobe_n = 1'b1;
        output_gate = 1'b1;
    end
    task automatic capture(input logic [7:0] d);
        channel_in <= d;
        capture_strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        capture_strobe_n <= 1'b1;
        repeat (2) @(posedge clk);
        // Inputs flip after capture so a leak into the outputs shows
        channel_in <= ~d;
        @(posedge clk);
    endtask
    task automatic transfer();
        transfer_strobe_n <= 1'b0;
        repeat (XFER_PULSE_MIN_CYCLES) @(posedge clk);
        transfer_strobe_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic drive(input logic cap, input logic xfer, input logic [7:0] d);
        capture_strobe_n <= cap;
        transfer_strobe_n <= xfer;
        channel_in <= d;
        @(posedge clk);
    endtask
    task automatic gate_pulse();
        output_gate <= 1'b0;
        repeat (GATE_MIN_CYCLES) @(posedge clk);
        output_gate <= 1'b1;
        @(posedge clk);
    endtask
endmodule

// >>> verif/osp_tb_top.sv
// Self-checking testbench of the parallel control block
`timescale 1ns/1ps
module osp_tb_top;
    import osp_pkg::*;
    localparam int WD_LEN = 6000;
    localparam int REF_LEN = 200;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [NUM_CH-1:0] channel_in;
    logic capture_strobe_n;
    logic transfer_strobe_n;
    logic output_gate;
    logic [NUM_CH-1:0] channel_out;
    int err_total = 0;
    int checks = 0;
    always #2.5 hclk = ~hclk;
    osp_host host (.clk(hclk), .channel_in, .capture_strobe_n, .transfer_strobe_n,
        .output_gate);
    osp_top #(.REFRESH_LEN(REF_LEN), .WD_LEN(WD_LEN), .FRAME_LEN(16)) dut (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .channel_in, .capture_strobe_n, .transfer_strobe_n,
        .output_gate, .channel_out);
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected word at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [7:0] exp);
        chk_word({24'h0, channel_out}, {24'h0, exp});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wait_out(input logic [7:0] exp, input int n);
        for (int i = 0; i < n && channel_out !== exp; i++)
            @(posedge hclk);
        chk_out(exp);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        logic [31:0] rd;
        chk_out(8'h00);
        bus(1'b0, CTRL_ADDR, 32'h0, rd);
        chk_word(rd, 32'h1);
        bus(1'b0, STAT_ADDR, 32'h0, rd);
        chk_word(rd & 32'h00ffffff, 32'h0);
        bus(1'b1, 8'h08, 32'hffffffff, rd);
        bus(1'b0, 8'h08, 32'h0, rd);
        chk_word(rd, 32'h0);
    endtask
    task automatic t_latched(input logic [7:0] prev, input logic [7:0] d);
        logic [31:0] rd;
        host.capture(d);
        idle(30);
        chk_out(prev);
        bus(1'b0, STAT_ADDR, 32'h0, rd);
        chk_word({24'h0, rd[STAT_INBUF_LSB +: 8]}, {24'h0, d});
        host.transfer();
        chk_out(prev);
        bus(1'b0, STAT_ADDR, 32'h0, rd);
        chk_word({24'h0, rd[STAT_TXBUF_LSB +: 8]}, {24'h0, d});
        wait_out(d, 40);
        idle(2 * REF_LEN);
        chk_out(d);
    endtask
    task automatic t_gate(input logic [7:0] d);
        fork
            host.gate_pulse();
            begin
                idle(12);
                chk_out(8'h00);
            end
        join
        idle(4);
        chk_out(8'h00);
        wait_out(d, REF_LEN + 40);
    endtask
    task automatic t_watchdog(input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, CTRL_ADDR, 32'h0, rd);
        idle(WD_LEN + REF_LEN);
        chk_out(8'h00);
        bus(1'b0, STAT_ADDR, 32'h0, rd);
        chk_word({31'h0, rd[STAT_WD_BIT]}, 32'h1);
        bus(1'b1, CTRL_ADDR, 32'h1, rd);
        wait_out(d, REF_LEN + 40);
        idle(WD_LEN + REF_LEN);
        chk_out(d);
    endtask
    task automatic t_corrupt(input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, CTRL_ADDR, 32'h3, rd);
        wait_out(8'h00, REF_LEN + 40);
        bus(1'b0, STAT_ADDR, 32'h0, rd);
        chk_word({31'h0, rd[STAT_ERR_BIT]}, 32'h1);
        wait_out(d, REF_LEN + 40);
    endtask
    task automatic t_direct();
        host.drive(1'b0, 1'b0, 8'h3c);
        wait_out(8'h3c, 40);
        host.drive(1'b0, 1'b0, 8'hc3);
        wait_out(8'hc3, 40);
        host.gate_pulse();
        chk_out(8'h00);
        wait_out(8'hc3, 40);
        host.drive(1'b1, 1'b1, 8'hc3);
        host.drive(1'b1, 1'b1, 8'h0f);
        idle(2 * REF_LEN);
        chk_out(8'hc3);
    endtask
    task automatic t_midreset();
        logic [31:0] rd;
        hresetn <= 1'b0;
        idle(4);
        hresetn <= 1'b1;
        idle(1);
        chk_out(8'h00);
        bus(1'b0, STAT_ADDR, 32'h0, rd);
        chk_word(rd & 32'h00ffff00, 32'h0);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial
    begin
        idle(4);
        hresetn <= 1'b1;
        idle(1);
        t_reset();
        t_latched(8'h00, 8'ha5);
        t_latched(8'ha5, 8'h5a);
        t_gate(8'h5a);
        t_watchdog(8'h5a);
        t_corrupt(8'h5a);
        t_direct();
        t_midreset();
        give_verdict();
    end
    // Run takes about 22k cycles; the 80k-cycle limit leaves wide margin
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end
endmodule
